// ==== uafm_pkg.sv ====
package uafm_pkg;

  // ----------------------------------------------------------------
  // Register offsets, byte addresses within one instance
  // ----------------------------------------------------------------
  localparam logic [4:0] OFF_DATA = 5'h00;
  localparam logic [4:0] OFF_IER = 5'h04;
  localparam logic [4:0] OFF_IIR = 5'h08;
  localparam logic [4:0] OFF_LCR = 5'h0C;
  localparam logic [4:0] OFF_MCR = 5'h10;
  localparam logic [4:0] OFF_LSR = 5'h14;
  localparam logic [4:0] OFF_MSR = 5'h18;
  localparam logic [4:0] OFF_SCR = 5'h1C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int LCR_PEN = 3;
  localparam int LCR_EPS = 4;
  localparam int LCR_STB = 2;
  localparam int LCR_BRK = 6;
  localparam int LCR_DLAB = 7;
  localparam int MCR_DTR = 0;
  localparam int MCR_RTS = 1;
  localparam int MCR_LOOP = 4;
  localparam int FCR_EN = 0;
  localparam int FCR_RXR = 1;
  localparam int FCR_TXR = 2;
  localparam int IER_RDA = 0;
  localparam int IER_THRE = 1;
  localparam int IER_RLS = 2;
  localparam int IER_MS = 3;

  // ----------------------------------------------------------------
  // Sizes, reset values, codes and tick counts
  // ----------------------------------------------------------------
  localparam int NUM_INST = 4;
  localparam int FIFO_DEPTH = 16;
  localparam int ERR_BITS = 3;
  localparam logic [7:0] LCR_RST = 8'h00;
  localparam logic [15:0] DIV_RST = 16'h0000;
  localparam logic [3:0] IIR_NONE = 4'h1;
  localparam logic [3:0] IIR_RLS = 4'h6;
  localparam logic [3:0] IIR_RDA = 4'h4;
  localparam logic [3:0] IIR_THRE = 4'h2;
  localparam logic [3:0] IIR_MS = 4'h0;
  localparam logic [3:0] TICK_HALF = 4'h7;
  localparam logic [3:0] TICK_LAST = 4'hF;
  localparam logic [5:0] STOP1_LAST = 6'h0F;
  localparam logic [5:0] STOP15_LAST = 6'h17;
  localparam logic [5:0] STOP2_LAST = 6'h1F;

  typedef struct packed {
    logic [4:0] off;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } uafm_req_t;

  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_START = 5'b00010,
    S_DATA = 5'b00100,
    S_PAR = 5'b01000,
    S_STOP = 5'b10000
  } uafm_state_t;

endpackage

// ==== uafm_top.sv ====
// Function
// - Character mode after reset; FIFO mode: 16-deep FIFOs, 3 error bits
// - Baud divisor 1..65535 makes a 16x tick for the transmitter
// - Same 16x tick drives the receiver
// - Five to eight data bits both ways
// - Even, odd or no parity generated and checked
// - One, one-and-a-half or two stop bits
// - Parity, overrun, framing, break status readable any time
// - A start low that does not persist is rejected
// - Break sent on request and detected on input
// - Loopback routes transmit data into the receiver internally
// - Four interrupt sources each enabled on its own
// - Ring status falling raises modem interrupt when enabled
// - Control bit 0 drives terminal ready low; reset or loop hold high
// - Control bit 1 drives request to send low; reset or loop hold high
// - Clear to send at status bit 4, change flagged, no transmit gating
// - Status bit 5 inverted set ready; bit 1 flags its change
// - Bit 7 inverted carrier; bit 3 flags change; no receive effect
// - Any change of clear to send, set ready or carrier raises interrupt when enabled
// - Serial output marks high from reset until transmission
// - Ring input of instance 0 is also a wake request
// - Four instances; only instance 0 has modem lines
// - Enable bit 3 gates modem interrupt; status still updates
// - Priority line, data, holding empty, modem; id frozen on read
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ns

module uafm_channel
  import uafm_pkg::*;
#(
  parameter bit HAS_MODEM = 1'b1,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire uafm_req_t req,
  output logic [7:0] rdata,
  input wire logic rx_in,
  output logic tx_out_reg,
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic ri_n,
  input wire logic dcd_n,
  output logic dtr_n_reg,
  output logic rts_n_reg,
  output logic irq_reg
);
  localparam int AW = $clog2(DEPTH);
  localparam int RW = 8 + ERR_BITS;

  // Pointer wrap and trigger levels need a power of two of at least 16
  if (DEPTH < 16 || (1 << AW) != DEPTH) begin : g_chk
    $error("uafm_channel: DEPTH must be a power of two >= 16");
  end

  function automatic logic [7:0] len_mask(input logic [1:0] wls);
    len_mask = 8'hFF >> (2'd3 - wls);
  endfunction

  // ----------------------------------------------------------------
  // Registers and access decode
  // ----------------------------------------------------------------
  logic [7:0] lcr_reg, scr_reg;
  logic [3:0] ier_reg;
  logic [2:0] mcr_reg;
  logic [15:0] div_reg, bcnt_reg;
  logic fen_reg;
  logic [1:0] trig_reg;
  logic [3:0] iid_reg;

  wire dlab = lcr_reg[LCR_DLAB];
  wire loop = mcr_reg[2];
  wire at_data = req.off == OFF_DATA;
  wire at_ier = req.off == OFF_IER;
  wire at_iir = req.off == OFF_IIR;
  wire wr_thr = req.wr && at_data && !dlab;
  wire rd_rbr = req.rd && at_data && !dlab;
  wire wr_dll = req.wr && at_data && dlab;
  wire wr_dlm = req.wr && at_ier && dlab;
  wire wr_ier = req.wr && at_ier && !dlab;
  wire wr_fcr = req.wr && at_iir;
  wire rd_iir = req.rd && at_iir;
  wire rd_lsr = req.rd && req.off == OFF_LSR;
  wire rd_msr = req.rd && req.off == OFF_MSR;
  wire [7:0] wd = req.wdata;
  wire fifo_mode_chg = wr_fcr && (wd[FCR_EN] != fen_reg);
  wire tx_clr = wr_fcr && (wd[FCR_TXR] || fifo_mode_chg);
  wire rx_clr = wr_fcr && (wd[FCR_RXR] || fifo_mode_chg);
  wire [AW:0] cap = fen_reg ? (AW+1)'(DEPTH) : (AW+1)'(1);
  wire [7:0] wmask = len_mask(lcr_reg[1:0]);
  wire [2:0] last_bit = {1'b1, lcr_reg[1:0]};
  wire pen = lcr_reg[LCR_PEN];
  wire eps = lcr_reg[LCR_EPS];

  // Control registers; data and mode bits written by software
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      lcr_reg <= LCR_RST;
      ier_reg <= '0;
      mcr_reg <= '0;
      scr_reg <= '0;
      div_reg <= DIV_RST;
      fen_reg <= 1'b0;
      trig_reg <= '0;
    end else if (ce) begin
      if (req.wr && req.off == OFF_LCR) lcr_reg <= wd;
      if (wr_ier) ier_reg <= wd[3:0];
      if (req.wr && req.off == OFF_MCR)
        mcr_reg <= {wd[MCR_LOOP], wd[MCR_RTS], wd[MCR_DTR]};
      if (req.wr && req.off == OFF_SCR) scr_reg <= wd;
      if (wr_dll) div_reg[7:0] <= wd;
      if (wr_dlm) div_reg[15:8] <= wd;
      // Mode select, character mode at reset
      if (wr_fcr) fen_reg <= wd[FCR_EN];
      if (wr_fcr) trig_reg <= wd[7:6];
    end
  end

  // ----------------------------------------------------------------
  // Baud generator
  // ----------------------------------------------------------------
  // Divisor zero stalls the tick rather than dividing by 65536
  wire tick = (div_reg != 16'h0000) && (bcnt_reg == div_reg - 16'h0001);

  always_ff @(posedge mclk) begin
    if (sys_rst) bcnt_reg <= '0;
    else if (ce) bcnt_reg <= (tick || wr_dll || wr_dlm) ? '0 :
                             bcnt_reg + 16'h0001;
  end

  // ----------------------------------------------------------------
  // Transmit FIFO and serialiser
  // ----------------------------------------------------------------
  logic [7:0] txm [DEPTH];
  logic [AW-1:0] twp_reg, trp_reg;
  logic [AW:0] tcnt_reg;
  uafm_state_t tst_reg;
  logic [5:0] ttk_reg;
  logic [2:0] tbit_reg;
  logic [7:0] tsh_reg;
  logic tpar_reg, tline_reg, thre_reg;

  // Character mode holds one byte, FIFO mode holds DEPTH
  wire tx_push = wr_thr && tcnt_reg < cap;
  wire tx_load = tick && tst_reg == S_IDLE && tcnt_reg != '0;
  wire [5:0] ttk_inc = ttk_reg + 6'h01;
  // 1.5 stops only with five bits, otherwise 2
  wire [5:0] stop_last = !lcr_reg[LCR_STB] ? STOP1_LAST :
                         (lcr_reg[1:0] == 2'b00) ? STOP15_LAST : STOP2_LAST;
  wire tbit_end = ttk_reg[3:0] == TICK_LAST;
  wire [AW:0] tcnt_next = tx_clr ? '0 :
    tcnt_reg + (AW+1)'(tx_push) - (AW+1)'(tx_load);
  // Break forces the line to space
  wire tx_bit = tline_reg && !lcr_reg[LCR_BRK];

  // Holding store and its pointers
  always_ff @(posedge mclk) begin
    if (ce && tx_push) txm[twp_reg] <= wr_thr ? wd : 8'h00;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst || (ce && tx_clr)) begin
      twp_reg <= '0;
      trp_reg <= '0;
    end else if (ce) begin
      if (tx_push) twp_reg <= twp_reg + AW'(1);
      if (tx_load) trp_reg <= trp_reg + AW'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) tcnt_reg <= '0;
    else if (ce) tcnt_reg <= tcnt_next;
  end

  // Shift sequencer runs on the 16x tick
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tst_reg <= S_IDLE;
      ttk_reg <= '0;
      tbit_reg <= '0;
      tsh_reg <= '0;
      tpar_reg <= 1'b0;
      tline_reg <= 1'b1;
    end else if (ce && tick) begin
      ttk_reg <= ttk_inc;
      unique case (tst_reg)
        S_IDLE: begin
          tline_reg <= 1'b1;
          if (tcnt_reg != '0) begin
            // Unused high bits are masked off
            tsh_reg <= txm[trp_reg] & wmask;
            tpar_reg <= ^(txm[trp_reg] & wmask) ^ !eps;
            tline_reg <= 1'b0;
            ttk_reg <= '0;
            tst_reg <= S_START;
          end
        end
        S_START: if (tbit_end) begin
          ttk_reg <= '0;
          tbit_reg <= '0;
          tline_reg <= tsh_reg[0];
          tst_reg <= S_DATA;
        end
        S_DATA: if (tbit_end) begin
          ttk_reg <= '0;
          tsh_reg <= tsh_reg >> 1;
          tbit_reg <= tbit_reg + 3'd1;
          tline_reg <= tsh_reg[1];
          if (tbit_reg == last_bit) begin
            tline_reg <= pen ? tpar_reg : 1'b1;
            tst_reg <= pen ? S_PAR : S_STOP;
          end
        end
        S_PAR: if (tbit_end) begin
          ttk_reg <= '0;
          tline_reg <= 1'b1;
          tst_reg <= S_STOP;
        end
        S_STOP: if (ttk_reg == stop_last) tst_reg <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Receive deserialiser and FIFO
  // ----------------------------------------------------------------
  logic [RW-1:0] rxm [DEPTH];
  logic [AW-1:0] rwp_reg, rrp_reg;
  logic [AW:0] rcnt_reg;
  uafm_state_t rst_reg;
  logic [3:0] rtk_reg;
  logic [2:0] rbit_reg;
  logic [7:0] rsh_reg;
  logic rpar_reg, oe_reg;
  logic [ERR_BITS-1:0] err_reg;

  // Loopback feeds the transmit bit straight back in
  wire rx_line = loop ? tx_bit : rx_in;
  wire [7:0] rx_data = rsh_reg >> (2'd3 - lcr_reg[1:0]);
  wire rx_done = tick && rst_reg == S_STOP && rtk_reg == TICK_LAST;
  // Parity check against the selected sense
  wire rx_pe = pen && (rpar_reg != (^rx_data ^ !eps));
  // Framing error when the first stop bit is space
  wire rx_fe = !rx_line;
  // All-space character including parity and stop
  wire rx_bi = rx_data == 8'h00 && !rx_line && !(pen && rpar_reg);
  wire rx_push = rx_done && rcnt_reg < cap;
  wire rx_ovr = rx_done && rcnt_reg >= cap;
  wire rx_pop = rd_rbr && rcnt_reg != '0;
  wire [ERR_BITS-1:0] rx_err = {rx_bi, rx_fe, rx_pe};
  wire [RW-1:0] rx_head = rxm[rrp_reg];

  // Each stored byte keeps its three error bits
  always_ff @(posedge mclk) begin
    if (ce && rx_push) rxm[rwp_reg] <= {rx_err, rx_data};
  end

  always_ff @(posedge mclk) begin
    if (sys_rst || (ce && rx_clr)) begin
      rwp_reg <= '0;
      rrp_reg <= '0;
      rcnt_reg <= '0;
    end else if (ce) begin
      if (rx_push) rwp_reg <= rwp_reg + AW'(1);
      if (rx_pop) rrp_reg <= rrp_reg + AW'(1);
      rcnt_reg <= rcnt_reg + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
    end
  end

  // Receiver shares the transmitter's 16x tick
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rst_reg <= S_IDLE;
      rtk_reg <= '0;
      rbit_reg <= '0;
      rsh_reg <= '0;
      rpar_reg <= 1'b0;
    end else if (ce && tick) begin
      rtk_reg <= rtk_reg + 4'h1;
      unique case (rst_reg)
        S_IDLE: begin
          rtk_reg <= '0;
          if (!rx_line) rst_reg <= S_START;
        end
        // Confirm start at its midpoint, then count full bits
        S_START: if (rtk_reg == TICK_HALF) begin
          rtk_reg <= '0;
          rbit_reg <= '0;
          // A glitch that is gone by mid-bit is dropped
          rst_reg <= rx_line ? S_IDLE : S_DATA;
        end
        S_DATA: if (rtk_reg == TICK_LAST) begin
          rsh_reg <= {rx_line, rsh_reg[7:1]};
          rbit_reg <= rbit_reg + 3'd1;
          // Bit count follows the selected length
          if (rbit_reg == last_bit) rst_reg <= pen ? S_PAR : S_STOP;
        end
        S_PAR: if (rtk_reg == TICK_LAST) begin
          rpar_reg <= rx_line;
          rst_reg <= S_STOP;
        end
        S_STOP: if (rtk_reg == TICK_LAST) rst_reg <= S_IDLE;
      endcase
    end
  end

  // Sticky line errors, cleared by a status read; set wins
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      oe_reg <= 1'b0;
      err_reg <= '0;
    end else if (ce) begin
      oe_reg <= (oe_reg && !rd_lsr) || rx_ovr;
      err_reg <= (rd_lsr ? '0 : err_reg) | (rx_push ? rx_err : '0);
    end
  end

  // ----------------------------------------------------------------
  // Modem lines
  // ----------------------------------------------------------------
  logic [3:0] mst_prev_reg, delta_reg;

  // Status order is carrier, ring, set ready, clear to send
  // Instances without modem lines read inactive
  // Clear to send is status only, never a transmit gate
  // Carrier is status only, never a receive gate
  wire [3:0] mst_pin = HAS_MODEM ? {!dcd_n, !ri_n, !dsr_n, !cts_n} : 4'h0;
  wire [3:0] mst = loop ? {2'b00, mcr_reg[0], mcr_reg[1]} : mst_pin;
  wire [3:0] mchg = mst ^ mst_prev_reg;
  // Ring input low to high means status bit falling
  wire [3:0] mev = {mchg[3], mst_prev_reg[2] && !mst[2], mchg[1], mchg[0]};

  // Status read clears all change flags; a new event wins
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mst_prev_reg <= '0;
      delta_reg <= '0;
    end else if (ce) begin
      mst_prev_reg <= mst;
      delta_reg <= (rd_msr ? 4'h0 : delta_reg) | mev;
    end
  end

  // Terminal ready; reset and loop keep it high
  // Request to send; reset and loop keep it high
  // Output marks from reset; loop also marks it
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      dtr_n_reg <= 1'b1;
      rts_n_reg <= 1'b1;
      tx_out_reg <= 1'b1;
    end else if (ce) begin
      dtr_n_reg <= !(mcr_reg[0] && !loop);
      rts_n_reg <= !(mcr_reg[1] && !loop);
      tx_out_reg <= loop || tx_bit;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt priority
  // ----------------------------------------------------------------
  // THRE source is armed when the holding side drains empty
  wire thre_set = (tcnt_next == '0 && tcnt_reg != '0) ||
    (wr_ier && wd[IER_THRE] && !ier_reg[IER_THRE] && tcnt_reg == '0);
  wire thre_clr = wr_thr || (rd_iir && iid_reg == IIR_THRE);
  wire [1:0] tsel = trig_reg;
  wire [AW:0] trig_lvl = (tsel == 2'd0) ? (AW+1)'(1) :
                         (tsel == 2'd1) ? (AW+1)'(4) :
                         (tsel == 2'd2) ? (AW+1)'(8) : (AW+1)'(14);
  // Each source gated by its own enable
  wire src_rls = ier_reg[IER_RLS] && (oe_reg || err_reg != '0);
  wire src_rda = ier_reg[IER_RDA] && rcnt_reg != '0 &&
                 (!fen_reg || rcnt_reg >= trig_lvl);
  wire src_thre = ier_reg[IER_THRE] && thre_reg;
  // Ring trailing edge feeds the modem source
  // Any change of the other three lines feeds the modem source
  // Masked by enable bit 3 while flags still update
  wire src_ms = ier_reg[IER_MS] && delta_reg != 4'h0;
  wire [3:0] iid_next = src_rls ? IIR_RLS : src_rda ? IIR_RDA :
                        src_thre ? IIR_THRE : src_ms ? IIR_MS : IIR_NONE;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      thre_reg <= 1'b0;
      iid_reg <= IIR_NONE;
      irq_reg <= 1'b0;
    end else if (ce) begin
      thre_reg <= (thre_reg && !thre_clr) || thre_set;
      // Identification held while the CPU reads it
      if (!rd_iir) iid_reg <= iid_next;
      irq_reg <= iid_next != IIR_NONE;
    end
  end

  // ----------------------------------------------------------------
  // Read data, selected by offset
  // ----------------------------------------------------------------
  wire [7:0] lsr = {fen_reg && err_reg != '0, tcnt_reg == '0 &&
    tst_reg == S_IDLE, tcnt_reg == '0, err_reg, oe_reg, rcnt_reg != '0};
  wire [7:0] mcr_rd = {3'b000, mcr_reg[2], 2'b00, mcr_reg[1:0]};

  // Line status readable at any time
  // Modem status is levels over change flags
  always_comb begin
    unique case (req.off)
      OFF_DATA: rdata = dlab ? div_reg[7:0] : rx_head[7:0];
      OFF_IER: rdata = dlab ? div_reg[15:8] : {4'h0, ier_reg};
      OFF_IIR: rdata = {fen_reg, fen_reg, 2'b00, iid_reg};
      OFF_LCR: rdata = lcr_reg;
      OFF_MCR: rdata = mcr_rd;
      OFF_LSR: rdata = lsr;
      OFF_MSR: rdata = {mst, delta_reg};
      OFF_SCR: rdata = scr_reg;
      default: rdata = 8'h00;
    endcase
  end
endmodule

module uafm_top
  import uafm_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [NUM_INST-1:0] serial_rx_in,
  output logic [NUM_INST-1:0] serial_tx_out,
  input wire logic clear_to_send_in_n,
  input wire logic set_ready_in_n,
  input wire logic ring_indicate_in_n,
  input wire logic carrier_detect_in_n,
  output logic terminal_ready_out_n,
  output logic request_to_send_out_n,
  output logic [NUM_INST-1:0] uart_irq,
  output logic wake_request
);
  logic [7:0] rd_all [NUM_INST];
  wire [1:0] inst = reg_addr[6:5];

  // Four instances, modem lines on instance 0 only
  for (genvar i = 0; i < NUM_INST; i++) begin : g_ch
    uafm_req_t req;
    assign req.off = reg_addr[4:0];
    assign req.wdata = reg_wdata;
    assign req.wr = reg_wr && inst == 2'(i);
    assign req.rd = reg_rd && inst == 2'(i);
    if (i == 0) begin : g_modem
      uafm_channel #(.HAS_MODEM(1'b1), .DEPTH(FIFO_DEPTH)) u_ch (
        .mclk(mclk), .sys_rst(sys_rst), .ce(ce), .req(req),
        .rdata(rd_all[i]), .rx_in(serial_rx_in[i]),
        .tx_out_reg(serial_tx_out[i]),
        .cts_n(clear_to_send_in_n), .dsr_n(set_ready_in_n),
        .ri_n(ring_indicate_in_n), .dcd_n(carrier_detect_in_n),
        .dtr_n_reg(terminal_ready_out_n),
        .rts_n_reg(request_to_send_out_n), .irq_reg(uart_irq[i]));
    end else begin : g_plain
      uafm_channel #(.HAS_MODEM(1'b0), .DEPTH(FIFO_DEPTH)) u_ch (
        .mclk(mclk), .sys_rst(sys_rst), .ce(ce), .req(req),
        .rdata(rd_all[i]), .rx_in(serial_rx_in[i]),
        .tx_out_reg(serial_tx_out[i]),
        .cts_n(1'b1), .dsr_n(1'b1), .ri_n(1'b1), .dcd_n(1'b1),
        .dtr_n_reg(), .rts_n_reg(), .irq_reg(uart_irq[i]));
    end
  end

  // Read data stands only in the cycle after the strobe
  // Ring of instance 0 doubles as a wake request
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
      wake_request <= 1'b0;
    end else if (ce) begin
      reg_rdata <= reg_rd ? rd_all[inst] : 8'h00;
      wake_request <= !ring_indicate_in_n;
    end
  end
endmodule

// ==== uafm_top_props.sv ====
`timescale 1ns/1ns

module uafm_top_props
  import uafm_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [NUM_INST-1:0] serial_tx_out,
  input wire logic ring_indicate_in_n,
  input wire logic terminal_ready_out_n,
  input wire logic request_to_send_out_n,
  input wire logic [NUM_INST-1:0] uart_irq,
  input wire logic wake_request
);
  // ------------------------------------------------------------
  // Control write decode and loop mirror
  // ------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic mcr_wr;
  logic loop_reg;
  assign mcr_wr = ce && reg_wr && reg_addr == {2'h0, OFF_MCR};
  // Loop bit of instance 0, so the pin checks know the mode
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      loop_reg <= 1'b0;
    end else if (mcr_wr) begin
      loop_reg <= reg_wdata[MCR_LOOP];
    end
  end
  // Read data stands only after a read strobe
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside answer cycle");
  a_tx_mark_reset: assert property ($past(sys_rst) |->
    serial_tx_out == '1)
    else $error("serial output not marking after reset");
  a_irq_reset: assert property ($past(sys_rst) |-> uart_irq == '0)
    else $error("interrupt active after reset");
  a_dtr_follow: assert property (mcr_wr && !reg_wdata[MCR_LOOP]
    |-> ##2 terminal_ready_out_n == !$past(reg_wdata[MCR_DTR], 2))
    else $error("terminal ready does not follow control bit");
  a_rts_follow: assert property (mcr_wr && !reg_wdata[MCR_LOOP]
    |-> ##2 request_to_send_out_n == !$past(reg_wdata[MCR_RTS], 2))
    else $error("request to send does not follow control bit");
  a_loop_outs_high: assert property (
    $past(loop_reg) && loop_reg |->
    terminal_ready_out_n && request_to_send_out_n)
    else $error("modem outputs active in loop mode");
  a_loop_tx_mark: assert property ($past(loop_reg) && loop_reg |->
    serial_tx_out[0])
    else $error("serial output not held high in loop mode");
  a_wake_ring: assert property (!$past(sys_rst) |->
    wake_request == !$past(ring_indicate_in_n))
    else $error("wake request does not follow ring input");
endmodule

bind uafm_top uafm_top_props uafm_top_props_i (.mclk, .sys_rst, .ce,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .serial_tx_out,
  .ring_indicate_in_n, .terminal_ready_out_n, .request_to_send_out_n,
  .uart_irq, .wake_request);

// ==== uafm_partner.sv ====
`timescale 1ns/1ns

module uafm_partner (
  input wire logic mclk,
  output logic rx_line,
  output logic [3:0] lines_n
);
  // Line marks and modem lines stay inactive until a scenario moves them
  initial begin
    rx_line = 1'b1;
    lines_n = 4'hF;
  end
  // Hold one level for n cycles; one bit is 16 cycles at divisor 1
  task automatic drive(input logic v, input int n);
    @(posedge mclk);
    rx_line <= v;
    repeat (n - 1) @(posedge mclk);
  endtask
  // Start, data LSB first, even parity if asked (spoilt on request), stop
  task automatic send(input logic [7:0] d, input logic par, input logic bad);
    drive(1'b0, 16);
    for (int i = 0; i < 8; i++) drive(d[i], 16);
    if (par) drive(^d ^ bad, 16);
    drive(1'b1, 16);
  endtask
  // Modem lines ordered carrier, ring, set ready, clear to send
  task automatic set_lines(input logic [3:0] v);
    @(posedge mclk);
    lines_n <= v;
  endtask
endmodule

// ==== tb_uart_fifo_modem_control.sv ====
`timescale 1ns/1ns

module tb_uart_fifo_modem_control
  import uafm_pkg::*;
;
  logic mclk;
  logic sys_rst;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic rx0;
  logic [3:0] ln;
  logic [3:0] tx;
  logic dtr_n;
  logic rts_n;
  logic [3:0] irq;
  logic wake;
  logic [7:0] rv;
  int n_fail;
  int num_checks;
  uafm_top uafm_top_i (.mclk(mclk), .sys_rst(sys_rst), .ce(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_rx_in({3'h7, rx0}),
    .serial_tx_out(tx), .clear_to_send_in_n(ln[0]), .set_ready_in_n(ln[1]),
    .ring_indicate_in_n(ln[2]), .carrier_detect_in_n(ln[3]),
    .terminal_ready_out_n(dtr_n), .request_to_send_out_n(rts_n),
    .uart_irq(irq), .wake_request(wake));
  uafm_partner uafm_partner_i (.mclk(mclk), .rx_line(rx0), .lines_n(ln));
  // ------------------------------------------------------------
  // Bus cycles and comparison
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Extra edge at the end keeps back-to-back strobes apart
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    reg_addr <= {2'h0, a};
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [4:0] a, input logic [1:0] u = 2'h0);
    reg_addr <= {u, a};
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
    @(posedge mclk);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [7:0] e,
                     input logic [1:0] u = 2'h0);
    rd(a, u);
    chk(rv, e);
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    chk({4'h0, tx}, 8'h0F);
    chk({6'h0, dtr_n, rts_n}, 8'h03);
    rdc(OFF_IIR, 8'h01);
    rdc(OFF_LSR, 8'h60);
    rdc(OFF_MSR, 8'h00, 2'h1);
    rdc(5'h02, 8'h00);
    wr(OFF_IIR, 8'h01);
    rdc(OFF_IIR, 8'hC1);
    wr(OFF_IIR, 8'h00);
    $display("test reset done");
  endtask
  // Divisor 1 gives a 16-cycle bit; sample each bit at its middle
  task automatic t_tx();
    int i;
    logic [9:0] f;
    f = {1'b1, 8'hA5, 1'b0};
    wr(OFF_LCR, 8'h80);
    wr(OFF_DATA, 8'h01);
    wr(OFF_IER, 8'h00);
    wr(OFF_LCR, 8'h03);
    wr(OFF_DATA, 8'hA5);
    for (i = 0; i < 200 && tx[0] !== 1'b0; i++) @(posedge mclk);
    if (i == 200) begin
      n_fail++;
      wrap_up();
    end
    repeat (8) @(posedge mclk);
    for (i = 0; i < 10; i++) begin
      chk({7'h0, tx[0]}, {7'h0, f[i]});
      repeat (16) @(posedge mclk);
    end
    wr(OFF_LCR, 8'h43);
    @(posedge mclk);
    chk({7'h0, tx[0]}, 8'h00);
    wr(OFF_LCR, 8'h03);
    $display("test transmit done");
  endtask
  // Partner send blocks until the stop bit, so status is read once
  task automatic t_rx();
    uafm_partner_i.send(8'h3C, 1'b0, 1'b0);
    rdc(OFF_LSR, 8'h61);
    rdc(OFF_DATA, 8'h3C);
    wr(OFF_LCR, 8'h1B);
    uafm_partner_i.send(8'h0F, 1'b1, 1'b1);
    rdc(OFF_LSR, 8'h65);
    rdc(OFF_DATA, 8'h0F);
    wr(OFF_LCR, 8'h03);
    uafm_partner_i.drive(1'b0, 300);
    uafm_partner_i.drive(1'b1, 32);
    rd(OFF_LSR);
    chk(rv & 8'h11, 8'h11);
    rdc(OFF_DATA, 8'h00);
    uafm_partner_i.drive(1'b0, 4);
    uafm_partner_i.drive(1'b1, 60);
    rdc(OFF_LSR, 8'h60);
    $display("test receive done");
  endtask
  // Loop data goes back into the receiver while the pins rest
  task automatic t_loop();
    int i;
    wr(OFF_MCR, 8'h03);
    @(posedge mclk);
    chk({6'h0, dtr_n, rts_n}, 8'h00);
    wr(OFF_MCR, 8'h13);
    @(posedge mclk);
    chk({6'h0, dtr_n, rts_n}, 8'h03);
    wr(OFF_DATA, 8'h5A);
    for (i = 0; i < 100 && rv[0] !== 1'b1; i++) rd(OFF_LSR);
    if (rv[0] !== 1'b1) begin
      n_fail++;
      wrap_up();
    end
    rdc(OFF_DATA, 8'h5A);
    wr(OFF_MCR, 8'h00);
    $display("test loop done");
  endtask
  task automatic t_modem();
    rd(OFF_MSR);
    uafm_partner_i.set_lines(4'h0);
    repeat (4) @(posedge mclk);
    chk({3'h0, wake, irq}, 8'h10);
    rdc(OFF_MSR, 8'hFB);
    rdc(OFF_MSR, 8'hF0);
    wr(OFF_IER, 8'h08);
    uafm_partner_i.set_lines(4'h4);
    repeat (4) @(posedge mclk);
    chk({4'h0, irq}, 8'h01);
    rdc(OFF_MSR, 8'hB4);
    @(posedge mclk);
    chk({4'h0, irq}, 8'h00);
    uafm_partner_i.set_lines(4'h5);
    repeat (4) @(posedge mclk);
    chk({4'h0, irq}, 8'h01);
    rdc(OFF_IIR, 8'h00);
    rdc(OFF_MSR, 8'hA1);
    wr(OFF_IER, 8'h00);
    $display("test modem done");
  endtask
  // 250 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    sys_rst = 1'b1;
    reg_addr = 7'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    n_fail = 0;
    num_checks = 0;
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    t_reset();
    t_tx();
    t_rx();
    t_loop();
    t_modem();
    wrap_up();
  end
endmodule
